// ---- sdci_pkg.sv ----
// Purpose: Constants and types for the synchronous DRAM command interface
// Assumes: 125 MHz clock, four banks, 32-bit data in four byte lanes
// Notes:   Timing figures are in nanoseconds; cycle counts derive from them
package sdci_pkg;
   localparam int CLK_PERIOD_NS       = 8;       // Clock period
   localparam int REFRESH_INTERVAL_NS = 15625;   // Distributed refresh interval
   localparam int REFRESH_ROWS        = 4096;    // Rows in the refresh counter
   localparam int ROW_W               = 12;      // Row address width
   localparam int COL_W               = 9;       // Column address width
   localparam int AUTOCLOSE_BIT       = 10;      // Autoclose select position
   localparam int BANKS               = 4;       // Number of banks
   localparam int LANES               = 4;       // Byte lanes
   localparam int MASK_LAT            = 2;       // Read mask latency
   localparam int MODE_BL_LSB         = 0;       // Burst length field
   localparam int MODE_LAT_LSB        = 4;       // Read latency field
   localparam int MODE_WB_BIT         = 9;       // Single write burst
   localparam logic [11:0] MODE_RESET = 12'h0_022; // Length 4, latency 2
   localparam logic [2:0]  BL_FULL    = 3'h7;    // Full page code
   localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;

   // One-hot decoded commands
   typedef enum logic [7:0] {
      SDCI_NOP   = 8'h01,
      SDCI_ACT   = 8'h02,
      SDCI_RD    = 8'h04,
      SDCI_WR    = 8'h08,
      SDCI_BT    = 8'h10,
      SDCI_PRE   = 8'h20,
      SDCI_REF   = 8'h40,
      SDCI_MRS   = 8'h80
   } sdci_cmd_t;

   // Burst length in beats for a mode code; zero for full page and for codes 4 to 6
   function automatic logic [9:0] sdci_burst_len(input logic [2:0] code);
      unique case (code)
         3'h0:    return 10'h001;
         3'h1:    return 10'h002;
         3'h2:    return 10'h004;
         3'h3:    return 10'h008;
         default: return 10'h000;
      endcase
   endfunction : sdci_burst_len
endpackage : sdci_pkg

// ---- sdci_cmd_if.sv ----
// Purpose: Carries one decoded command between decoder and core
// Assumes: One command per cycle
// Notes:   Valid is high in every selected cycle outside self refresh
`timescale 1ns/1ps
interface sdci_cmd_if;
   import sdci_pkg::*;
   logic            valid;   // Command strobe
   sdci_cmd_t       cmd;     // Decoded command
   logic [1:0]      bank;    // Bank select
   logic [11:0]     addr;    // Address inputs
   logic            self_ref; // Clock enable was low, for any command
   modport dec (output valid, output cmd, output bank, output addr, output self_ref);
   modport core (input valid, input cmd, input bank, input addr, input self_ref);
endinterface : sdci_cmd_if

// ---- sdci_decode.sv ----
// Purpose: Registers and decodes the strobe pins
// Assumes: Inputs synchronous to clk
// Notes:   Self refresh blocks all decoding until clock enable returns
`timescale 1ns/1ps
module sdci_decode
   import sdci_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       cs_n,
   input  wire logic       row_strobe_n,
   input  wire logic       col_strobe_n,
   input  wire logic       write_en_n,
   input  wire logic       clk_en,
   input  wire logic       in_self_ref,
   input  wire logic [1:0] bank,
   input  wire logic [11:0] addr,
   sdci_cmd_if.dec         cmd_o
);
   logic      valid_d;
   sdci_cmd_t cmd_d;

   // Strobe decode
   always_comb
   begin
      valid_d = !cs_n && !in_self_ref;
      unique case ({row_strobe_n, col_strobe_n, write_en_n})
         3'b111:  cmd_d = SDCI_NOP;
         3'b011:  cmd_d = SDCI_ACT;
         3'b101:  cmd_d = SDCI_RD;
         3'b100:  cmd_d = SDCI_WR;
         3'b110:  cmd_d = SDCI_BT;
         3'b010:  cmd_d = SDCI_PRE;
         3'b001:  cmd_d = SDCI_REF;
         default: cmd_d = SDCI_MRS;
      endcase
   end

   // Register the command
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cmd_o.valid    <= 1'b0;
         cmd_o.cmd      <= SDCI_NOP;
         cmd_o.bank     <= 2'h0;
         cmd_o.addr     <= 12'h0_000;
         cmd_o.self_ref <= 1'b0;
      end
      else
      begin
         cmd_o.valid    <= valid_d;
         cmd_o.cmd      <= cmd_d;
         cmd_o.bank     <= bank;
         cmd_o.addr     <= addr;
         cmd_o.self_ref <= !clk_en;
      end
   end

   AST_CS_BLOCKS: assert property (@(posedge clk) disable iff (reset)
      cs_n |=> !cmd_o.valid) else $error("Command taken while deselected");
   AST_DECODE_RD: assert property (@(posedge clk) disable iff (reset)
      (!cs_n && !in_self_ref && {row_strobe_n, col_strobe_n, write_en_n} == 3'b101)
      |=> cmd_o.valid && cmd_o.cmd == SDCI_RD) else $error("Read not decoded");
endmodule : sdci_decode

// ---- sdci_rdpipe.sv ----
// Purpose: Read data latency pipe with byte-lane masks
// Assumes: Latency 1 to 3
// Notes:   Mask delay is fixed at two clocks
`timescale 1ns/1ps
module sdci_rdpipe
   import sdci_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        beat,
   input  wire logic [31:0] data,
   input  wire logic [1:0]  latency,
   input  wire logic [3:0]  mask,
   output logic [31:0]      dq_o,
   output logic [3:0]       dq_oe
);
   logic [2:0]  beat_q, beat_d;     // Beat delay line
   logic [31:0] data_q [3];         // Data delay line
   logic [31:0] data_d [3];
   logic [7:0]  mask_q, mask_d;     // Two-stage mask history
   logic [31:0] dq_d;
   logic [3:0]  oe_d;
   logic        sel;

   // Pipeline next state
   always_comb
   begin
      beat_d    = {beat_q[1:0], beat};
      data_d[0] = data;
      data_d[1] = data_q[0];
      data_d[2] = data_q[1];
      mask_d    = {mask_q[3:0], mask};
      unique case (latency)
         2'h1:    sel = beat;
         2'h3:    sel = beat_q[1];
         default: sel = beat_q[0];
      endcase
      dq_d = (latency == 2'h1) ? data : (latency == 2'h3) ? data_q[1] : data_q[0];
      // Lanes drive on the same edge as the data; mask registered two clocks ago gates them
      oe_d = sel ? ~mask_q[7:4] : 4'h0;
   end

   // Registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         beat_q <= 3'h0;
         mask_q <= 8'h00;
         data_q <= '{default: 32'h0000_0000};
         dq_o   <= 32'h0000_0000;
         dq_oe  <= 4'h0;
      end
      else
      begin
         beat_q <= beat_d;
         mask_q <= mask_d;
         data_q <= data_d;
         dq_o   <= dq_d;
         dq_oe  <= oe_d;
      end
   end
endmodule : sdci_rdpipe

// ---- sdci_core.sv ----
// Purpose: Synchronous DRAM command interface, device side
// Assumes: Controller keeps its ordering and timing duties
// Notes:   Small internal array models one word per column per bank
`timescale 1ns/1ps
module sdci_core
   import sdci_pkg::*;
#(
   parameter int MEM_COLS = 512   // Columns kept per bank
)(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        cs_n,
   input  wire logic        row_strobe_n,
   input  wire logic        col_strobe_n,
   input  wire logic        write_en_n,
   input  wire logic        clk_en,
   input  wire logic        bank_select_lo,
   input  wire logic        bank_select_hi,
   input  wire logic [11:0] addr,
   input  wire logic [3:0]  byte_mask,
   input  wire logic [31:0] dq_i,
   output logic [31:0]      dq_o,
   output logic [3:0]       dq_oe,
   output logic [3:0]       bank_open,
   output logic [11:0]      mode_reg,
   output logic [11:0]      refresh_row,
   output logic             self_refresh
);
   sdci_cmd_if cmd ();

   // Bank, row, mode and refresh state
   logic [3:0]  open_q, open_d;
   logic [11:0] row_q [4];
   logic [11:0] row_d [4];
   logic [11:0] mode_q, mode_d;
   logic [11:0] rrow_q, rrow_d;
   logic        sref_q, sref_d;
   // Burst state
   logic        rd_q, rd_d;            // Read burst running
   logic        wr_q, wr_d;            // Write burst running
   logic [1:0]  bbank_q, bbank_d;
   logic [8:0]  col_q, col_d;
   logic [9:0]  left_q, left_d;       // Beats left, zero means full page
   logic        ac_q, ac_d;           // Autoclose pending
   logic        full_q, full_d;
   // Storage and outputs
   logic [31:0] mem [4][MEM_COLS];
   logic        mem_we;
   logic [31:0] mem_wdata;
   logic [31:0] rdata;
   logic        rbeat;
   logic [3:0]  open_out_q;
   logic        last_beat;
   logic        cmd_burst;
   logic [9:0]  blen;

   sdci_decode u_dec (
      .clk          (clk),
      .reset        (reset),
      .cs_n         (cs_n),
      .row_strobe_n (row_strobe_n),
      .col_strobe_n (col_strobe_n),
      .write_en_n   (write_en_n),
      .clk_en       (clk_en),
      .in_self_ref  (sref_q),
      .bank         ({bank_select_hi, bank_select_lo}),
      .addr         (addr),
      .cmd_o        (cmd)
   );

   // Burst length for the command being taken
   always_comb
   begin
      blen      = sdci_burst_len(mode_q[MODE_BL_LSB +: 3]);
      cmd_burst = cmd.valid && (cmd.cmd == SDCI_RD || cmd.cmd == SDCI_WR);
      last_beat = (rd_q || wr_q) && !full_q && left_q == 10'h001;
   end

   // Bank, mode, refresh and burst next state
   always_comb
   begin
      open_d = open_q;
      row_d  = row_q;
      mode_d = mode_q;
      rrow_d = rrow_q;
      sref_d = sref_q;
      rd_d   = rd_q;
      wr_d   = wr_q;
      bbank_d = bbank_q;
      col_d  = col_q;
      left_d = left_q;
      ac_d   = ac_q;
      full_d = full_q;
      // Advance a running burst
      if (rd_q || wr_q)
      begin
         col_d = col_q + 9'h001;   // Full page wraps within the row
         if (!full_q)
            left_d = left_q - 10'h001;
         if (last_beat)
         begin
            rd_d = 1'b0;
            wr_d = 1'b0;
            if (ac_q)
               open_d[bbank_q] = 1'b0;
         end
      end
      // Leave self refresh once clock enable returns
      if (sref_q && clk_en)
         sref_d = 1'b0;
      if (cmd.valid)
      begin
         unique case (cmd.cmd)
            SDCI_NOP: ;
            SDCI_ACT:
            begin
               open_d[cmd.bank] = 1'b1;
               row_d[cmd.bank]  = cmd.addr;
            end
            SDCI_RD, SDCI_WR:
            begin
               rd_d    = cmd.cmd == SDCI_RD;
               wr_d    = cmd.cmd == SDCI_WR;
               bbank_d = cmd.bank;
               col_d   = cmd.addr[COL_W-1:0];
               full_d  = mode_q[MODE_BL_LSB +: 3] == BL_FULL;
               left_d  = (cmd.cmd == SDCI_WR && mode_q[MODE_WB_BIT]) ? 10'h001 : blen;
               ac_d    = cmd.addr[AUTOCLOSE_BIT] && !full_d;
            end
            SDCI_BT:
            begin
               rd_d = 1'b0;
               wr_d = 1'b0;
               ac_d = 1'b0;
            end
            SDCI_PRE:
            begin
               if (cmd.addr[AUTOCLOSE_BIT])
                  open_d = 4'h0;
               else
                  open_d[cmd.bank] = 1'b0;
            end
            SDCI_REF:
            begin
               rrow_d = rrow_q + 12'h001;
               if (cmd.self_ref)
                  sref_d = 1'b1;
            end
            SDCI_MRS: mode_d = cmd.addr;
            default: ;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         open_q  <= 4'h0;
         row_q   <= '{default: 12'h0_000};
         mode_q  <= MODE_RESET;
         rrow_q  <= 12'h0_000;
         sref_q  <= 1'b0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         bbank_q <= 2'h0;
         col_q   <= 9'h000;
         left_q  <= 10'h000;
         ac_q    <= 1'b0;
         full_q  <= 1'b0;
         open_out_q <= 4'h0;
      end
      else
      begin
         open_q  <= open_d;
         row_q   <= row_d;
         mode_q  <= mode_d;
         rrow_q  <= rrow_d;
         sref_q  <= sref_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
         bbank_q <= bbank_d;
         col_q   <= col_d;
         left_q  <= left_d;
         ac_q    <= ac_d;
         full_q  <= full_d;
         open_out_q <= open_d;
      end
   end

   // Write beat merge: byte lanes with mask low are stored
   always_comb
   begin
      mem_we    = wr_q;
      mem_wdata = mem[bbank_q][col_q];
      for (int i = 0; i < LANES; i++)
         if (!byte_mask[i])
            mem_wdata[8*i +: 8] = dq_i[8*i +: 8];
      rbeat = rd_q;
      rdata = mem[bbank_q][col_q];
   end

   // Array write, only clocked storage with no reset
   always_ff @(posedge clk)
   begin
      if (mem_we)
         mem[bbank_q][col_q] <= mem_wdata;
   end

   sdci_rdpipe u_rd (
      .clk     (clk),
      .reset   (reset),
      .beat    (rbeat),
      .data    (rdata),
      .latency (mode_q[MODE_LAT_LSB +: 2]),
      .mask    (byte_mask),
      .dq_o    (dq_o),
      .dq_oe   (dq_oe)
   );

   assign bank_open    = open_out_q;
   assign mode_reg     = mode_q;
   assign refresh_row  = rrow_q;
   assign self_refresh = sref_q;

   // Read command sequence: a valid read taken by the core
   sequence s_read_taken;
      cmd.valid && cmd.cmd == SDCI_RD;
   endsequence

   AST_READ_STARTS: assert property (@(posedge clk) disable iff (reset)
      s_read_taken |=> rd_q) else $error("Read burst did not start");
   AST_WRITE_STARTS: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_WR |=> wr_q && col_q == $past(cmd.addr[8:0]))
      else $error("Write burst wrong start");
   AST_ACT_OPENS: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_ACT |=> open_q[$past(cmd.bank)] && row_q[$past(cmd.bank)] == $past(cmd.addr))
      else $error("Activate did not open bank");
   AST_PRE_ALL: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_PRE && cmd.addr[10] |=> open_q == 4'h0)
      else $error("Precharge all left a bank open");
   AST_BT_STOPS: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_BT |=> !rd_q && !wr_q)
      else $error("Burst terminate ignored");
   AST_MODE_LOAD: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_MRS |=> mode_q == $past(cmd.addr))
      else $error("Mode register not loaded");
   AST_REF_COUNT: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_REF |=> rrow_q == $past(rrow_q) + 12'h001)
      else $error("Refresh counter did not step");
   AST_SREF_ENTRY: assert property (@(posedge clk) disable iff (reset)
      cmd.valid && cmd.cmd == SDCI_REF && cmd.self_ref |=> sref_q)
      else $error("Self refresh not entered");
   AST_SREF_HOLD: assert property (@(posedge clk) disable iff (reset)
      sref_q && !clk_en |=> !cmd.valid) else $error("Command taken in self refresh");
   AST_AUTOCLOSE: assert property (@(posedge clk) disable iff (reset)
      last_beat && ac_q && !(cmd.valid && cmd.cmd == SDCI_ACT) |=> !open_q[$past(bbank_q)])
      else $error("Autoclose did not close bank");
endmodule : sdci_core

// ---- sdci_ctrl_model.sv ----
// Purpose: Memory controller model that drives every command pin
// Assumes: Pins change on the falling clock edge, sampled on the rising
// Notes:   Idle cycles are selected no-ops with address lines scrambled
`timescale 1ns/1ps
module sdci_ctrl_model
   import sdci_pkg::*;
#(
   parameter int PRECHARGE_TIME_NS   = 20,  // Minimum precharge time
   parameter int ROW_ACTIVE_TIME_NS  = 42,  // Minimum row active time
   parameter int SR_EXIT_TIME_NS     = 70,  // Minimum self refresh exit time
   parameter int REFRESH_CYC_TIME_NS = 66   // Minimum refresh cycle time
)(
   input  wire logic clk,
   output logic      cs_n,
   output logic      row_strobe_n,
   output logic      col_strobe_n,
   output logic      write_en_n,
   output logic      clk_en,
   output logic      bank_select_lo,
   output logic      bank_select_hi,
   output logic [11:0] addr,
   output logic [3:0]  byte_mask,
   output logic [31:0] dq_i
);
   // Limits rounded up to whole cycles
   localparam int PRE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_CYC = (ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC_CYC = (REFRESH_CYC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_RAW = (SR_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_CYC = (XSR_RAW < 2) ? 2 : XSR_RAW;
   int extra = 0;   // Extra no-ops that make the controller slow

   // Deselected and quiet at time zero
   initial
   begin
      {cs_n, row_strobe_n, col_strobe_n, write_en_n, clk_en} = 5'h1f;
      {bank_select_hi, bank_select_lo} = 2'h0;
      addr = 12'h000;
      byte_mask = 4'h0;
      dq_i = 32'h0000_0000;
   end

   // One command with its data and mask
   task automatic cmd(input logic [2:0] code, input logic [1:0] b, input logic [11:0] a,
                      input logic cke, input logic csn, input logic [31:0] d, input logic [3:0] m);
      @(negedge clk);
      cs_n <= csn;
      {row_strobe_n, col_strobe_n, write_en_n} <= code;
      {bank_select_hi, bank_select_lo} <= b;
      addr <= a;
      clk_en <= cke;
      dq_i <= d;
      byte_mask <= m;
   endtask : cmd

   // No-ops; clock enable and mask are held, stale lines toggle
   task automatic idle(input int n);
      repeat (n + extra)
      begin
         @(negedge clk);
         cs_n <= 1'b0;
         {row_strobe_n, col_strobe_n, write_en_n} <= 3'h7;
         addr <= ~addr;
         {bank_select_hi, bank_select_lo} <= ~{bank_select_hi, bank_select_lo};
         dq_i <= ~dq_i;
      end
   endtask : idle

   // Leave self refresh with the clock already running
   task automatic wake();
      @(negedge clk);
      clk_en <= 1'b1;
      idle(XSR_CYC);
   endtask : wake
endmodule : sdci_ctrl_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the DRAM command interface
// Assumes: Controller model drives all pins on the falling edge
// Notes:   Read beats are matched in arrival order against a queue
`timescale 1ns/1ps
module tb_top;
   import sdci_pkg::*;
   localparam logic [2:0] C_ACT = 3'h3, C_RD = 3'h5, C_WR = 3'h4, C_BT = 3'h6;  // Strobe codes
   localparam logic [2:0] C_PRE = 3'h2, C_REF = 3'h1, C_MRS = 3'h0;
   typedef struct packed { logic [3:0] oe; logic [31:0] d; } sdci_beat_t;  // One expected beat
   logic        clk, reset;             // Clock and reset
   logic        cs_n, row_strobe_n, col_strobe_n, write_en_n, clk_en;
   logic        bank_select_lo, bank_select_hi;
   logic [11:0] addr, mode_reg, refresh_row;
   logic [3:0]  byte_mask, dq_oe, bank_open;
   logic [31:0] dq_i, dq_o;
   logic        self_refresh;
   int          mismatches = 0;         // Failed comparisons
   int          samples_checked = 0;    // All comparisons
   sdci_beat_t  exp_q[$];               // Expected read beats
   logic [31:0] seed = 32'h0000_4ee4;   // Random state
   bit          no_data = 1'b0;         // Count beats without comparing
   int          fp_beats = 0;           // Beats seen while counting
   logic [11:0] modes [3] = '{12'h0_231, 12'h0_037, 12'h0_030};  // Legal modes, latency 3

   sdci_ctrl_model u_ctrl (.clk(clk), .cs_n(cs_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .write_en_n(write_en_n), .clk_en(clk_en), .bank_select_lo(bank_select_lo),
      .bank_select_hi(bank_select_hi), .addr(addr), .byte_mask(byte_mask), .dq_i(dq_i));
   sdci_core #(.MEM_COLS(512)) u_dut (.clk(clk), .reset(reset), .cs_n(cs_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .clk_en(clk_en), .bank_select_lo(bank_select_lo),
      .bank_select_hi(bank_select_hi), .addr(addr), .byte_mask(byte_mask), .dq_i(dq_i), .dq_o(dq_o),
      .dq_oe(dq_oe), .bank_open(bank_open), .mode_reg(mode_reg), .refresh_row(refresh_row),
      .self_refresh(self_refresh));

   // Free-running 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Xorshift random source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // Compares a state output
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t state got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Compares one read beat on its enabled lanes
   task automatic cmp_beat(input logic [3:0] oe, input logic [31:0] d, input sdci_beat_t e);
      logic [31:0] lm;
      lm = {{8{e.oe[3]}}, {8{e.oe[2]}}, {8{e.oe[1]}}, {8{e.oe[0]}}};
      samples_checked++;
      if (oe !== e.oe || (d & lm) !== (e.d & lm))
      begin
         mismatches++;
         $display("[ERR] %0t beat got %h/%h want %h/%h", $time, oe, d, e.oe, e.d);
      end
   endtask : cmp_beat

   // Command, then no-ops
   task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input int n,
                     input logic [31:0] d = 32'h0000_0000, input logic [3:0] m = 4'h0);
      u_ctrl.cmd(c, b, a, 1'b1, 1'b0, d, m);
      u_ctrl.idle(n);
   endtask : op

   // Watches the data outputs; each beat takes the oldest note
   always @(negedge clk)
      if (reset === 1'b0 && dq_oe !== 4'h0)
      begin
         if (no_data)
            fp_beats++;
         else if (exp_q.size() == 0)
            cmp_beat(dq_oe, dq_o, '0);
         else
            cmp_beat(dq_oe, dq_o, exp_q.pop_front());
      end

   // Cuts a hang short
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      stop_test();
   end

   // Main sequence
   initial
   begin
      logic [31:0] d0, d1, wmk;
      logic [8:0]  col;
      logic [1:0]  b;
      logic [3:0]  wm, rm;
      logic [11:0] r0;
      int          n;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      chk(32'(mode_reg), 32'(MODE_RESET));
      chk({bank_open, dq_oe, 11'h0, self_refresh, refresh_row}, 32'h0000_0000);
      // Mode loads, all with latency 3 at this clock rate
      foreach (modes[i])
      begin
         op(C_MRS, 2'(rnd()), modes[i], 6);
         chk(32'(mode_reg), 32'(modes[i]));
      end
      u_ctrl.cmd(C_MRS, 2'(rnd()), 12'h032, 1'b1, 1'b1, rnd(), 4'(rnd()));
      u_ctrl.idle(6);
      chk(32'(mode_reg), 32'h0000_0030);
      // Single-bank against all-bank precharge
      op(C_ACT, 2'h0, 12'(rnd()), 6);
      op(C_ACT, 2'h1, 12'(rnd()), 6);
      chk(32'(bank_open), 32'h0000_0003);
      op(C_PRE, 2'h0, 12'h000, 6);
      chk(32'(bank_open), 32'h0000_0002);
      op(C_PRE, 2'(rnd()), 12'h400, 6);
      chk(32'(bank_open), 32'h0000_0000);
      // Masked writes, masked reads, autoclose on odd passes, slower each pass
      for (int i = 0; i < 3; i++)
      begin
         u_ctrl.extra = i;
         b = 2'(rnd());
         col = 9'(rnd());
         d0 = rnd();
         d1 = rnd();
         wm = 4'(rnd());
         rm = 4'(rnd());
         if (rm == 4'hf)
            rm = 4'he;
         op(C_ACT, b, 12'(rnd()), 6);
         chk(32'(bank_open), 32'h0000_0001 << b);
         op(C_WR, b, {3'h0, col}, 6, d0, 4'h0);
         op(C_WR, b, {3'h0, col}, 6, d1, wm);
         wmk = {{8{wm[3]}}, {8{wm[2]}}, {8{wm[1]}}, {8{wm[0]}}};
         exp_q.push_back(sdci_beat_t'{~rm, (d0 & wmk) | (d1 & ~wmk)});
         u_ctrl.cmd(C_RD, b, {1'b0, i[0], 1'b0, col}, 1'b1, 1'b0, 32'h0, rm);
         fork
            u_ctrl.idle(12);
            begin
               @(posedge clk);
               n = 0;
               while (n < 12 && dq_oe === 4'h0)
               begin
                  @(posedge clk);
                  #1;
                  n++;
               end
               chk(32'(n), 32'd4);
               if (n == 12)
                  stop_test();
            end
         join
         chk(32'(bank_open), i[0] ? 32'h0 : 32'h1 << b);
         op(C_PRE, b, 12'h400, 6);
      end
      u_ctrl.extra = 0;
      // Full page read cut short by burst terminate; autoclose ignored
      op(C_MRS, 2'h0, 12'h037, 6);
      op(C_ACT, 2'h2, 12'(rnd()), 6);
      no_data = 1'b1;
      op(C_RD, 2'h2, 12'h400, 3);
      op(C_BT, 2'h0, 12'h000, 20);
      n = fp_beats;
      u_ctrl.idle(10);
      chk(32'(fp_beats == n && n >= 1 && n <= 10), 32'h1);
      chk(32'(bank_open), 32'h0000_0004);
      no_data = 1'b0;
      op(C_PRE, 2'h0, 12'h400, 6);
      op(C_MRS, 2'h0, 12'h030, 6);
      // Self refresh entry, ignored inputs, exit
      u_ctrl.cmd(C_REF, 2'(rnd()), 12'(rnd()), 1'b0, 1'b0, rnd(), 4'(rnd()));
      u_ctrl.idle(u_ctrl.RAS_CYC);
      chk(32'(self_refresh), 32'h1);
      u_ctrl.cmd(C_MRS, 2'(rnd()), 12'h031, 1'b0, 1'b0, rnd(), 4'(rnd()));
      u_ctrl.idle(6);
      chk(32'(mode_reg), 32'h0000_0030);
      u_ctrl.wake();
      chk(32'(self_refresh), 32'h0);
      // Auto refresh steps the internal row counter, address ignored
      for (int k = 0; k < 3; k++)
      begin
         r0 = refresh_row;
         op(C_REF, 2'(rnd()), 12'(rnd()), u_ctrl.RFC_CYC);
         chk(32'(refresh_row), 32'(12'(r0 + 12'h001)));
      end
      u_ctrl.idle(10);
      chk(32'(exp_q.size()), 32'h0);
      stop_test();
   end
endmodule : tb_top
